// file: logic/iec_pkg.sv
// package for the i/o bus error containment block: offsets, fields, types
// assumes one core clock; register reads arrive as a simple address/strobe port
package iec_pkg;
	localparam logic [11:0] OB_ADDR_LOG_OFFSET = 12'h070;
	localparam logic [11:0] CMPL_MSG_LOG_OFFSET = 12'h2a0;
	localparam logic [11:0] ERR_CFG_OFFSET = 12'h2b0;
	localparam logic [11:0] CTRL_OFFSET = 12'h2b8;
	localparam logic [11:0] STATUS_OFFSET = 12'h2c0;
	localparam int CFG_SMART_BIT = 0;
	localparam int CFG_HF_BIT = 1;
	localparam int CTRL_MEM_EN_BIT = 0;
	localparam int OB_INT_ACK_BIT = 0;
	localparam int OB_CONFIG_BIT = 1;
	localparam int OB_SPLIT_BIT = 2;
	localparam int CM_BYTE_COUNT_BIT = 32;
	localparam int CM_UNEX_SPLIT_BIT = 33;
	localparam int CM_DISC_BIT = 34;
	localparam int SC_BURST_BIT = 7;
	localparam logic [2:0] LATE_PHASE_FIRST = 3'h3;
	localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
	localparam logic [63:0] LOG_RESET = 64'h0;
	localparam logic [1:0] CFG_RESET = 2'h0;
	localparam logic [2:0] NON_PIO_MARK = 3'h4;

	typedef enum logic [2:0] {
		IEC_OB_PIO_RD = 3'b000,
		IEC_OB_PIO_WR = 3'b001,
		IEC_OB_IO_WR = 3'b010,
		IEC_OB_CFG = 3'b011,
		IEC_OB_INT_ACK = 3'b100,
		IEC_OB_SPLIT_CMPL = 3'b101,
		IEC_OB_QUICK_WR = 3'b110,
		IEC_OB_IO_RD = 3'b111
	} iec_ob_kind_t;

	typedef enum logic [1:0] {
		IEC_END_OK = 2'b00,
		IEC_END_MASTER_ABORT = 2'b01,
		IEC_END_TARGET_ABORT = 2'b10,
		IEC_END_PARITY = 2'b11
	} iec_end_t;

	// outcome of one outbound transaction on the i/o bus
	typedef struct packed {
		logic valid;
		iec_ob_kind_t kind;
		iec_end_t term;
		logic perr_seen;
		logic [63:0] addr;
		logic [63:0] start_addr;
		logic [2:0] phase;
		logic burst;
		logic internal;
	} iec_ob_done_t;

	// received split completion, checked against the outstanding table
	typedef struct packed {
		logic valid;
		logic own_req_id;
		logic tag_hit;
		logic seq_hit;
		logic bc_ok;
		logic is_err_msg;
		logic [31:0] message;
	} iec_sc_rx_t;

	typedef struct packed {
		logic valid;
		logic hard_fail;
		logic [63:0] data;
	} iec_ret_t;

	typedef enum logic [1:0] {
		IEC_ST_RUN = 2'b00,
		IEC_ST_FLUSH = 2'b01,
		IEC_ST_FATAL = 2'b10
	} iec_state_t;
endpackage

// file: logic/iec_log_reg.sv
// one 64-bit read-only log: loads only on a capture strobe
// assumes the capture strobe is already qualified by the caller
`timescale 1ns/1ps
`default_nettype none
module iec_log_reg (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic capture_in,
	input wire logic [63:0] value_in,
	output logic [63:0] value_out
);
	import iec_pkg::*;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			value_out <= LOG_RESET;
		end else if (capture_in) begin
			value_out <= value_in;
		end
	end
endmodule // iec_log_reg
`default_nettype wire

// file: logic/iec_top.sv
// error logging and containment for the outbound side of a link-to-i/o-bus bridge
// assumes register port strobes and bus outcome pulses are synchronous to clock_in
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - split completion with matching sequence but wrong byte count sets byte-count flag
// - own requester id with unmatched tag sets unexpected-completion flag
// - our split completion master or target aborted sets discarded flag
// - completion message field captured; meaningful only for split completion error messages
// - processor access logs address with low 2 bits zero; others set bit 63 (bits 63:61 = 4)
// - quick-write address may be approximate but within the failing block
// - configuration cycles log the bus address with one-hot device number
// - dma read returns log start address for phases 0-2, else phase address
// - interrupt acknowledge sets its flag; address then meaningless
// - configuration cycle sets configuration-access flag in outbound log
// - split completion log keeps address phase; bit 7 marks burst request
// - hard-fail select chooses hard-fail response, else all-ones data
// - error indication on aborts, read parity errors, or port write perr
// - in bus fatal mode every non-internal read, port write and config cycle gets the indication
// - reads of internal registers always return register contents
// - smart/dumb bit alters the ten error classes only, not link errors
// - pci-x bus may be smart or dumb
// - going fatal fakes outstanding split reads and drops dma read returns
// - memory-space enable clear means no inbound dma is claimed
// - dumb mode master abort goes fatal unless config or port space
module iec_top (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [63:0] reg_wdata_in,
	input wire logic [63:0] int_rdata_in,
	input wire iec_pkg::iec_ob_done_t ob_done_in,
	input wire iec_pkg::iec_sc_rx_t sc_rx_in,
	input wire logic [63:0] sc_addr_phase_in,
	input wire logic split_rd_pending_in,
	input wire logic dma_rd_pending_in,
	input wire logic dma_claim_req_in,
	output iec_pkg::iec_ret_t ret_out,
	output iec_pkg::iec_ret_t reg_ret_out,
	output logic fake_split_rd_out,
	output logic dma_ret_discard_out,
	output logic dma_claim_out,
	output logic bus_fatal_out
);
	import iec_pkg::*;

	logic [1:0] cfg_r;
	logic mem_en_r;
	iec_state_t state_r;
	iec_state_t state_nxt;
	iec_ret_t ret_r;
	iec_ret_t reg_ret_r;
	logic fake_r;
	logic discard_r;
	logic claim_r;
	// pin copy of the fatal state, loaded with state_r so both always agree
	logic fatal_r;
	logic [63:0] ob_log;
	logic [63:0] cm_log;

	wire smart = cfg_r[CFG_SMART_BIT];
	wire hard_fail_select = cfg_r[CFG_HF_BIT];
	wire fatal = (state_r != IEC_ST_RUN);
	wire d_valid = ob_done_in.valid && !ob_done_in.internal;
	wire is_read = (ob_done_in.kind == IEC_OB_PIO_RD) || (ob_done_in.kind == IEC_OB_IO_RD);
	wire is_port_wr = (ob_done_in.kind == IEC_OB_IO_WR);
	wire is_cfg = (ob_done_in.kind == IEC_OB_CFG);
	wire needs_ret = is_read || is_port_wr || is_cfg;
	wire aborted = (ob_done_in.term == IEC_END_MASTER_ABORT) || (ob_done_in.term == IEC_END_TARGET_ABORT);
	wire bad_read = is_read && (ob_done_in.term == IEC_END_PARITY);
	wire bad_port = is_port_wr && ob_done_in.perr_seen;
	wire ob_error = d_valid && (aborted || (ob_done_in.term == IEC_END_PARITY) || ob_done_in.perr_seen);
	// fake return for the read/port-write/config classes and blanket while fatal
	wire give_fail = d_valid && needs_ret && (aborted || bad_read || bad_port || fatal);
	wire give_data = d_valid && needs_ret && !give_fail;
	// internal register reads bypass the error path entirely
	wire give_internal = ob_done_in.valid && ob_done_in.internal;
	// no agent in dumb mode is fatal, except config or port space
	wire ma_fatal = (ob_done_in.term == IEC_END_MASTER_ABORT) && !is_cfg && !is_port_wr
		&& (ob_done_in.kind != IEC_OB_IO_RD);
	wire other_fatal = (ob_done_in.term == IEC_END_TARGET_ABORT) || (ob_done_in.term == IEC_END_PARITY)
		|| ob_done_in.perr_seen;
	wire go_fatal = d_valid && !smart && (ma_fatal || other_fatal);

	// outbound log value per transaction kind
	wire late_phase = ob_done_in.phase >= LATE_PHASE_FIRST;
	wire [63:0] sc_addr = late_phase ? ob_done_in.addr : ob_done_in.start_addr;
	logic [63:0] ob_val;
	always_comb begin
		ob_val = {NON_PIO_MARK, ob_done_in.addr[60:0]};
		unique case (ob_done_in.kind)
			IEC_OB_PIO_RD, IEC_OB_PIO_WR: ob_val = {ob_done_in.addr[63:2], 2'h0};
			IEC_OB_CFG: begin
				ob_val = {NON_PIO_MARK, ob_done_in.addr[60:0]}; // bus-side address
				ob_val[OB_CONFIG_BIT] = 1'b1;
			end
			IEC_OB_INT_ACK: begin
				ob_val = {NON_PIO_MARK, 61'h0};
				ob_val[OB_INT_ACK_BIT] = 1'b1;
			end
			IEC_OB_SPLIT_CMPL: begin
				ob_val = {NON_PIO_MARK, sc_addr[60:0]};
				ob_val[OB_SPLIT_BIT] = 1'b1;
				ob_val[SC_BURST_BIT] = ob_done_in.burst;
			end
			// quick writes log the block base, which is inside the failing block
			IEC_OB_QUICK_WR: ob_val = {NON_PIO_MARK, ob_done_in.addr[60:3], 3'h0};
			IEC_OB_IO_WR, IEC_OB_IO_RD: ob_val = {NON_PIO_MARK, ob_done_in.addr[60:0]};
		endcase
	end

	// completion message log: flags plus captured message
	wire sc_bc = sc_rx_in.valid && sc_rx_in.seq_hit && !sc_rx_in.bc_ok;
	wire sc_unex = sc_rx_in.valid && sc_rx_in.own_req_id && !sc_rx_in.tag_hit;
	wire sc_disc = d_valid && (ob_done_in.kind == IEC_OB_SPLIT_CMPL) && aborted;
	wire sc_msg = sc_rx_in.valid && sc_rx_in.is_err_msg;
	wire cm_cap = sc_bc || sc_unex || sc_disc || sc_msg;
	logic [63:0] cm_val;
	always_comb begin
		cm_val = cm_log;
		if (sc_msg) begin
			cm_val[31:0] = sc_rx_in.message;
		end
		cm_val[CM_BYTE_COUNT_BIT] = sc_bc;
		cm_val[CM_UNEX_SPLIT_BIT] = sc_unex;
		cm_val[CM_DISC_BIT] = sc_disc;
	end

	// logs only load from hardware events; writes never reach them
	iec_log_reg u_ob_log (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.capture_in(ob_error),
		.value_in(ob_val),
		.value_out(ob_log)
	);
	iec_log_reg u_cm_log (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.capture_in(cm_cap),
		.value_in(cm_val),
		.value_out(cm_log)
	);

	// register port decode
	wire wr_cfg = reg_wr_in && (reg_addr_in == ERR_CFG_OFFSET);
	wire wr_ctrl = reg_wr_in && (reg_addr_in == CTRL_OFFSET);
	logic [63:0] rd_mux;
	always_comb begin
		unique case (reg_addr_in)
			OB_ADDR_LOG_OFFSET: rd_mux = ob_log;
			CMPL_MSG_LOG_OFFSET: rd_mux = cm_log;
			ERR_CFG_OFFSET: rd_mux = {62'h0, cfg_r};
			CTRL_OFFSET: rd_mux = {63'h0, mem_en_r};
			STATUS_OFFSET: rd_mux = {62'h0, state_r};
			default: rd_mux = 64'h0;
		endcase
	end

	// fatal entry flushes one cycle of outstanding split state, then holds
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			IEC_ST_RUN: if (go_fatal) state_nxt = IEC_ST_FLUSH;
			IEC_ST_FLUSH: state_nxt = IEC_ST_FATAL;
			IEC_ST_FATAL: state_nxt = IEC_ST_FATAL; // left only by soft reset
			default: state_nxt = IEC_ST_FATAL;
		endcase
	end

	wire [63:0] ret_data = give_data ? int_rdata_in : ALL_ONES;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			cfg_r <= CFG_RESET;
			mem_en_r <= 1'b0;
			state_r <= IEC_ST_RUN;
			fatal_r <= 1'b0;
		end else begin
			if (wr_cfg) cfg_r <= reg_wdata_in[1:0];
			if (wr_ctrl) mem_en_r <= reg_wdata_in[CTRL_MEM_EN_BIT];
			state_r <= state_nxt;
			fatal_r <= (state_nxt != IEC_ST_RUN);
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			ret_r <= '0;
			reg_ret_r <= '0;
			fake_r <= 1'b0;
			discard_r <= 1'b0;
			claim_r <= 1'b0;
		end else begin
			ret_r.valid <= give_fail || give_data;
			ret_r.hard_fail <= give_fail && hard_fail_select;
			ret_r.data <= (give_fail && hard_fail_select) ? 64'h0 : ret_data;
			reg_ret_r.valid <= reg_rd_in || give_internal;
			reg_ret_r.hard_fail <= 1'b0;
			reg_ret_r.data <= give_internal ? int_rdata_in : rd_mux;
			fake_r <= (state_r == IEC_ST_FLUSH) && split_rd_pending_in;
			discard_r <= fatal && dma_rd_pending_in;
			claim_r <= dma_claim_req_in && mem_en_r;
		end
	end

	assign ret_out = ret_r;
	assign reg_ret_out = reg_ret_r;
	assign fake_split_rd_out = fake_r;
	assign dma_ret_discard_out = discard_r;
	assign dma_claim_out = claim_r;
	assign bus_fatal_out = fatal_r;

	// plain copies of fields that the checks look back at
	wire [52:0] ob_addr_hi = ob_done_in.addr[60:8];
	wire [52:0] ob_start_hi = ob_done_in.start_addr[60:8];
	wire ob_burst_seen = ob_done_in.burst;
	wire [31:0] sc_msg_seen = sc_rx_in.message;

	a_fail_in_fatal: assert property (@(posedge clock_in) disable iff (reset_in)
		(fatal && d_valid && needs_ret) |=> (ret_out.valid && (ret_out.hard_fail || ret_out.data == ALL_ONES)))
		else $error("no error indication while fatal");
	a_hf_select: assert property (@(posedge clock_in) disable iff (reset_in)
		(give_fail && hard_fail_select && !wr_cfg) |=> ret_out.hard_fail)
		else $error("hard fail not returned");
	a_ones_select: assert property (@(posedge clock_in) disable iff (reset_in)
		(give_fail && !hard_fail_select) |=> (!ret_out.hard_fail && ret_out.data == ALL_ONES))
		else $error("all ones not returned");
	a_internal_data: assert property (@(posedge clock_in) disable iff (reset_in)
		give_internal |=> (reg_ret_out.valid && reg_ret_out.data == $past(int_rdata_in)))
		else $error("internal read lost data");
	a_dumb_fatal: assert property (@(posedge clock_in) disable iff (reset_in)
		(!fatal && go_fatal) |=> bus_fatal_out ##1 bus_fatal_out)
		else $error("dumb error did not go fatal");
	a_smart_stays: assert property (@(posedge clock_in) disable iff (reset_in)
		(!fatal && smart && !go_fatal) |=> !bus_fatal_out)
		else $error("smart mode went fatal");
	a_pio_low_bits: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_PIO_RD) |=> (ob_log[1:0] == 2'h0))
		else $error("pio log low bits set");
	a_pio_wr_bits: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_PIO_WR) |=> (ob_log[1:0] == 2'h0))
		else $error("pio write log low bits set");
	a_nonpio_mark: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_CFG) |=> (ob_log[63:61] != 3'h0 && ob_log[OB_CONFIG_BIT]))
		else $error("config log marks missing");
	a_unex_flag: assert property (@(posedge clock_in) disable iff (reset_in)
		sc_unex |=> cm_log[CM_UNEX_SPLIT_BIT])
		else $error("unexpected completion not flagged");
	a_bc_flag: assert property (@(posedge clock_in) disable iff (reset_in)
		sc_bc |=> cm_log[CM_BYTE_COUNT_BIT])
		else $error("byte count error not flagged");
	a_disc_flag: assert property (@(posedge clock_in) disable iff (reset_in)
		sc_disc |=> cm_log[CM_DISC_BIT])
		else $error("discarded completion not flagged");
	a_msg_capture: assert property (@(posedge clock_in) disable iff (reset_in)
		sc_msg |=> (cm_log[31:0] == $past(sc_msg_seen)))
		else $error("completion message not captured");
	a_int_ack_flag: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_INT_ACK) |=> ob_log[OB_INT_ACK_BIT])
		else $error("interrupt acknowledge not flagged");
	a_split_burst: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_SPLIT_CMPL)
		|=> (ob_log[OB_SPLIT_BIT] && ob_log[SC_BURST_BIT] == $past(ob_burst_seen)))
		else $error("split completion marks wrong");
	a_split_start: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_SPLIT_CMPL && ob_done_in.phase < LATE_PHASE_FIRST)
		|=> (ob_log[60:8] == $past(ob_start_hi)))
		else $error("early phase did not log start address");
	a_split_late: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_SPLIT_CMPL && ob_done_in.phase >= LATE_PHASE_FIRST)
		|=> (ob_log[60:8] == $past(ob_addr_hi)))
		else $error("late phase did not log phase address");
	a_cfg_addr: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_CFG) |=> (ob_log[60:8] == $past(ob_addr_hi)))
		else $error("config bus address not logged");
	a_quick_block: assert property (@(posedge clock_in) disable iff (reset_in)
		(ob_error && ob_done_in.kind == IEC_OB_QUICK_WR) |=> (ob_log[60:8] == $past(ob_addr_hi)))
		else $error("quick write address outside block");
	a_hf_data: assert property (@(posedge clock_in) disable iff (reset_in)
		(give_fail && hard_fail_select) |=> (ret_out.hard_fail && ret_out.data == 64'h0))
		else $error("hard fail response carries data");
	a_good_data: assert property (@(posedge clock_in) disable iff (reset_in)
		give_data |=> (ret_out.valid && !ret_out.hard_fail && ret_out.data == $past(int_rdata_in)))
		else $error("clean read did not return data");
	a_port_exempt: assert property (@(posedge clock_in) disable iff (reset_in)
		(!fatal && d_valid && !smart && ob_done_in.kind == IEC_OB_IO_WR && !ob_done_in.perr_seen
		&& ob_done_in.term == IEC_END_MASTER_ABORT) |=> !bus_fatal_out)
		else $error("port space abort went fatal");
	a_fatal_holds: assert property (@(posedge clock_in) disable iff (reset_in)
		bus_fatal_out |=> bus_fatal_out)
		else $error("fatal mode left without reset");
	a_fake_split: assert property (@(posedge clock_in) disable iff (reset_in)
		($rose(bus_fatal_out) && split_rd_pending_in) |=> fake_split_rd_out)
		else $error("no fake return for split read");
	a_dma_discard: assert property (@(posedge clock_in) disable iff (reset_in)
		(bus_fatal_out && dma_rd_pending_in) |=> dma_ret_discard_out)
		else $error("dma read return not discarded");
	a_log_readonly: assert property (@(posedge clock_in) disable iff (reset_in)
		(!ob_error) |=> $stable(ob_log))
		else $error("outbound log changed without error");
	a_log_read: assert property (@(posedge clock_in) disable iff (reset_in)
		(reg_rd_in && reg_addr_in == OB_ADDR_LOG_OFFSET && !give_internal) |=> (reg_ret_out.data == $past(ob_log)))
		else $error("outbound log read wrong");
	a_no_claim: assert property (@(posedge clock_in) disable iff (reset_in)
		!mem_en_r |=> !dma_claim_out)
		else $error("dma claimed while memory disabled");
	c_go_fatal: cover property (@(posedge clock_in) disable iff (reset_in) !fatal ##1 fatal);
	c_hard_fail: cover property (@(posedge clock_in) disable iff (reset_in) ret_out.hard_fail);
	c_fake_split: cover property (@(posedge clock_in) disable iff (reset_in) fake_split_rd_out);
	c_byte_count: cover property (@(posedge clock_in) disable iff (reset_in) sc_bc);
	c_dma_discard: cover property (@(posedge clock_in) disable iff (reset_in) dma_ret_discard_out);
endmodule // iec_top
`default_nettype wire

// file: tb/iec_bus_model.sv
// far side model: i/o bus outcome source plus host-side answer watchdog
// assumes the bench raises go_in for one cycle, changed at the falling edge
`timescale 1ns/1ps
`default_nettype none
module iec_bus_model (
	input wire logic clock_in,
	input wire logic go_in,
	input wire logic [3:0] delay_in,
	input wire iec_pkg::iec_ob_done_t req_in,
	input wire logic answered_in,
	output iec_pkg::iec_ob_done_t done_out,
	output logic timed_out_out
);
	import iec_pkg::*;
	iec_ob_done_t hold_r;
	iec_ob_done_t nxt;
	logic busy_r;
	logic [3:0] wait_r;
	logic [7:0] silent_r;
	initial begin
		done_out = '0;
		hold_r = '0;
		busy_r = 1'b0;
		wait_r = 4'h0;
		silent_r = 8'h00;
		timed_out_out = 1'b0;
	end
	always @(posedge clock_in) begin
		// idle fields toggle so a design never sees a stale but plausible outcome
		nxt = ~done_out;
		nxt.valid = 1'b0;
		if (go_in) begin
			hold_r <= req_in;
			wait_r <= delay_in;
			busy_r <= 1'b1;
		end else if (busy_r && wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
		end else if (busy_r) begin
			nxt = hold_r;
			busy_r <= 1'b0;
		end
		done_out <= nxt;
		// host cannot trust a silent device, so it bounds the wait and logs it itself
		if (nxt.valid) silent_r <= 8'h01;
		else if (answered_in) silent_r <= 8'h00;
		else if (silent_r != 8'h00 && silent_r != 8'hff) silent_r <= silent_r + 8'h01;
		timed_out_out <= (silent_r > 8'h20);
	end
endmodule // iec_bus_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the error containment block
// assumes the bus model answers outbound ops; all stimulus changes at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	import iec_pkg::*;
	localparam logic [63:0] PA = 64'h0000_1234_5678_9abf;
	localparam logic [63:0] CA = 64'h0000_0000_0001_0800;
	localparam logic [63:0] SA = 64'h0000_0012_3400_0000;
	localparam logic [63:0] QA = 64'h0000_0000_8765_4321;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0, spend = 1'b0, dpend = 1'b0, creq = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [63:0] wd = 64'h0, ird = 64'h0123_4567_89ab_cdef, v;
	logic [3:0] dly = 4'h0;
	logic fk, disc, claim, fatal, f_s, tmo;
	iec_ob_done_t req = '0, obd;
	iec_sc_rx_t sc = '0;
	iec_ret_t ret, rret, r_s;
	int fail_count = 0, n_checks = 0, cyc = 0;
	iec_ob_kind_t ks[5] = '{IEC_OB_PIO_RD, IEC_OB_PIO_RD, IEC_OB_PIO_RD, IEC_OB_IO_WR, IEC_OB_IO_WR};
	iec_end_t ts[5] = '{IEC_END_MASTER_ABORT, IEC_END_TARGET_ABORT, IEC_END_PARITY, IEC_END_TARGET_ABORT, IEC_END_OK};
	logic [11:0] ra[4] = '{OB_ADDR_LOG_OFFSET, CMPL_MSG_LOG_OFFSET, ERR_CFG_OFFSET, 12'h100};
	iec_top iec_top_i(.clock_in(clk), .reset_in(rst), .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr),
		.reg_wdata_in(wd), .int_rdata_in(ird), .ob_done_in(obd), .sc_rx_in(sc), .sc_addr_phase_in(64'h0),
		.split_rd_pending_in(spend), .dma_rd_pending_in(dpend), .dma_claim_req_in(creq), .ret_out(ret),
		.reg_ret_out(rret), .fake_split_rd_out(fk), .dma_ret_discard_out(disc), .dma_claim_out(claim),
		.bus_fatal_out(fatal));
	iec_bus_model iec_bus_model_i(.clock_in(clk), .go_in(go), .delay_in(dly), .req_in(req),
		.answered_in(ret.valid | rret.valid), .done_out(obd), .timed_out_out(tmo));
	initial begin
		forever #4 clk = ~clk;
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			end_of_test;
		end
	end
	task chk(string n, logic [63:0] e, logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task chb(string n, logic e, logic g);
		chk(n, {63'h0, e}, {63'h0, g});
	endtask
	task rrd(logic [11:0] a);
		@(negedge clk) rd = 1'b1;
		addr = a;
		@(negedge clk) rd = 1'b0;
		for (int i = 0; i < 4 && rret.valid !== 1'b1; i++) @(negedge clk);
		v = rret.data;
	endtask
	task rwr(logic [11:0] a, logic [63:0] d);
		@(negedge clk) wr = 1'b1;
		addr = a;
		wd = d;
		@(negedge clk) wr = 1'b0;
	endtask
	task op(iec_ob_kind_t k, iec_end_t t, logic p, logic [63:0] a, logic [63:0] s, logic [2:0] ph, logic b, logic in);
		@(negedge clk) req = '{1'b1, k, t, p, a, s, ph, b, in};
		go = 1'b1;
		dly = dly ^ 4'h5;
		@(negedge clk) go = 1'b0;
		req = ~req;
		for (int i = 0; i < 16 && ret.valid !== 1'b1 && rret.valid !== 1'b1; i++) @(negedge clk);
		r_s = (ret.valid === 1'b1) ? ret : rret;
		f_s = fatal;
	endtask
	task scr(logic own, logic tag, logic seq, logic bc, logic em, logic [31:0] m);
		@(negedge clk) sc = '{1'b1, own, tag, seq, bc, em, m};
		@(negedge clk) sc = '{1'b0, ~own, ~tag, ~seq, ~bc, ~em, ~m};
		rrd(CMPL_MSG_LOG_OFFSET);
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		foreach (ra[i]) begin
			rrd(ra[i]);
			chk("reset read", LOG_RESET, v);
		end
		chb("claim at reset", 1'b0, claim);
		$display("test reset done");
		for (int h = 0; h < 2; h++) begin
			rwr(ERR_CFG_OFFSET, (64'(h) << CFG_HF_BIT) | 64'h1);
			for (int j = 0; j < 5; j++) begin
				op(ks[j], ts[j], j == 4, PA, 64'h0, 3'h0, 1'b0, 1'b0);
				chb("hard fail", h[0], r_s.hard_fail);
				chk("fake data", h ? 64'h0 : ALL_ONES, r_s.data);
				chb("smart fatal", 1'b0, f_s);
			end
		end
		op(IEC_OB_PIO_RD, IEC_END_MASTER_ABORT, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b1);
		chk("internal read", ird, r_s.data);
		op(IEC_OB_PIO_RD, IEC_END_OK, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b0);
		chb("good read fail", 1'b0, r_s.hard_fail);
		chk("good read data", ird, r_s.data);
		op(IEC_OB_PIO_RD, IEC_END_MASTER_ABORT, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b0);
		rrd(OB_ADDR_LOG_OFFSET);
		chk("pio log", {PA[63:2], 2'b00}, v);
		rwr(OB_ADDR_LOG_OFFSET, ALL_ONES);
		rwr(CMPL_MSG_LOG_OFFSET, ALL_ONES);
		rrd(OB_ADDR_LOG_OFFSET);
		chk("log after write", {PA[63:2], 2'b00}, v);
		$display("test smart done");
		op(IEC_OB_CFG, IEC_END_TARGET_ABORT, 1'b0, CA, 64'h0, 3'h0, 1'b0, 1'b0);
		rrd(OB_ADDR_LOG_OFFSET);
		chk("cfg mark", 64'(NON_PIO_MARK), 64'(v[63:61]));
		chb("cfg flag", 1'b1, v[OB_CONFIG_BIT]);
		chk("cfg addr", 64'(CA[60:8]), 64'(v[60:8]));
		op(IEC_OB_INT_ACK, IEC_END_TARGET_ABORT, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b0);
		rrd(OB_ADDR_LOG_OFFSET);
		chb("int ack flag", 1'b1, v[OB_INT_ACK_BIT]);
		for (int j = 0; j < 2; j++) begin
			op(IEC_OB_SPLIT_CMPL, IEC_END_TARGET_ABORT, 1'b0, PA, SA, j ? 3'h3 : 3'h2, j == 0, 1'b0);
			rrd(OB_ADDR_LOG_OFFSET);
			chb("split flag", 1'b1, v[OB_SPLIT_BIT]);
			chb("burst bit", j == 0, v[SC_BURST_BIT]);
			chk("split addr", j ? 64'(PA[60:8]) : 64'(SA[60:8]), 64'(v[60:8]));
			rrd(CMPL_MSG_LOG_OFFSET);
			chb("discarded", 1'b1, v[CM_DISC_BIT]);
		end
		op(IEC_OB_QUICK_WR, IEC_END_TARGET_ABORT, 1'b0, QA, 64'h0, 3'h0, 1'b0, 1'b0);
		rrd(OB_ADDR_LOG_OFFSET);
		chk("quick write addr", 64'(QA[31:3]), 64'(v[31:3]));
		scr(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
		chb("byte count", 1'b1, v[CM_BYTE_COUNT_BIT]);
		scr(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0);
		chb("unexpected", 1'b1, v[CM_UNEX_SPLIT_BIT]);
		scr(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 32'h0000_5a3c);
		chk("message", 64'h5a3c, 64'(v[31:0]));
		$display("test logs done");
		creq = 1'b1;
		repeat (2) @(negedge clk);
		chb("claim disabled", 1'b0, claim);
		rwr(CTRL_OFFSET, 64'h1);
		repeat (2) @(negedge clk);
		chb("claim enabled", 1'b1, claim);
		// agp and dumb pci-x buses both run here, so software selects dumb mode
		rwr(ERR_CFG_OFFSET, 64'h0);
		spend = 1'b1;
		dpend = 1'b1;
		op(IEC_OB_IO_WR, IEC_END_MASTER_ABORT, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b0);
		chk("port write data", ALL_ONES, r_s.data);
		chb("port space fatal", 1'b0, f_s);
		op(IEC_OB_CFG, IEC_END_MASTER_ABORT, 1'b0, CA, 64'h0, 3'h0, 1'b0, 1'b0);
		chb("config fatal", 1'b0, f_s);
		op(IEC_OB_PIO_RD, IEC_END_MASTER_ABORT, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b0);
		chb("dumb fatal", 1'b1, f_s);
		for (int i = 0; i < 4 && fk !== 1'b1; i++) @(negedge clk);
		chb("fake split", 1'b1, fk);
		chb("dma discard", 1'b1, disc);
		op(IEC_OB_PIO_RD, IEC_END_OK, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b0);
		chk("fatal read", ALL_ONES, r_s.data);
		op(IEC_OB_PIO_RD, IEC_END_OK, 1'b0, PA, 64'h0, 3'h0, 1'b0, 1'b1);
		chk("fatal internal", ird, r_s.data);
		$display("test dumb done");
		@(negedge clk) rst = 1'b1;
		@(negedge clk) rst = 1'b0;
		spend = 1'b0;
		dpend = 1'b0;
		chb("fatal cleared", 1'b0, fatal);
		chb("claim after reset", 1'b0, claim);
		rwr(CTRL_OFFSET, 64'h1);
		repeat (2) @(negedge clk);
		chb("claim re-enabled", 1'b1, claim);
		chb("host watchdog", 1'b0, tmo);
		$display("test recovery done");
		end_of_test;
	end
endmodule // tb
`default_nettype wire
